// *** hw/adc_host.sv ***
// Host controller that drives the six-channel converter through its pins.
// Assumes the converter's pins are synchronous to clk at 25 MHz, 3V timing.
`timescale 1ns/100ps
`include "adc_host_regs.svh"
module adc_host #(
   parameter int RESET_LOW_CYC = `RESET_LOW_CYC,
   parameter int RESET_TO_SAMPLE_CYC = `RESET_TO_SAMPLE_CYC
)(
   input wire logic clk,
   input wire logic srst,
   // User side
   input wire logic [2:0] sample_req,
   output logic sample_busy,
   input wire logic acc_valid,
   input wire adc_host_pkg::access_t acc_kind,
   input wire logic [2:0] acc_addr,
   input wire logic [7:0] acc_wdata,
   output logic acc_ready,
   output logic [15:0] rd_data,
   output logic rd_valid,
   output logic conv_done,
   // Converter side
   output logic conv_clk,
   output logic reset_n,
   output logic pair_a_sample_cmd_n,
   output logic pair_b_sample_cmd_n,
   output logic pair_c_sample_cmd_n,
   output logic chip_sel_n,
   output logic read_n,
   output logic write_n,
   output logic byte_mode,
   output logic addr_line_2,
   output logic addr_line_1,
   output logic addr_line_0,
   input wire logic [15:0] result_bus_in,
   output logic [7:0] result_bus_out,
   output logic [7:0] result_bus_oe,
   input wire logic conv_done_n,
   input wire logic first_word_flag
);
   import adc_host_pkg::*;

   typedef enum logic [1:0] {RS_PULSE, RS_WAIT, RS_READY} rst_state_t;
   typedef enum logic [2:0] {BS_IDLE, BS_SETUP, BS_STROBE, BS_HIGH_HALF,
      BS_RECOVER} bus_state_t;
   typedef enum logic [1:0] {SS_IDLE, SS_LOW, SS_HIGH} smp_state_t;

   logic rise_next;
   rst_state_t rs_reg, rs_next;
   logic [7:0] rcnt_reg, rcnt_next;
   bus_state_t bs_reg, bs_next;
   logic [3:0] bcnt_reg, bcnt_next;
   access_t kind_reg, kind_next;
   logic [2:0] addr_reg, addr_next;
   logic [7:0] wdat_reg, wdat_next;
   logic [15:0] rd_data_reg, rd_data_next;
   logic rd_valid_reg, rd_valid_next;
   logic byte_reg, byte_next;
   smp_state_t ss_reg, ss_next;
   logic [3:0] scnt_reg, scnt_next;
   logic [2:0] pend_reg, pend_next;
   logic [2:0] cmd_reg, cmd_next;

   conv_clk_gen #(
      .HALF_CYC(`CONV_CLK_HALF_CYC)
   ) u_clk (
      .clk(clk),
      .srst(srst),
      .conv_clk(conv_clk),
      .rise_next(rise_next)
   );

   eoc_detect u_eoc (
      .clk(clk),
      .srst(srst),
      .conv_done_n(conv_done_n),
      .done_pulse(conv_done)
   );

   // Reset sequencer: hold the converter in reset, then settle before sampling
   always_comb
   begin
      rs_next = rs_reg;
      rcnt_next = rcnt_reg;
      unique case (rs_reg)
         RS_PULSE:
            if (rcnt_reg == 8'(RESET_LOW_CYC - 1))
            begin
               rs_next = RS_WAIT;
               rcnt_next = 8'h0;
            end
            else
               rcnt_next = rcnt_reg + 8'h1;
         RS_WAIT:
            if (rcnt_reg == 8'(RESET_TO_SAMPLE_CYC - 1))
               rs_next = RS_READY;
            else
               rcnt_next = rcnt_reg + 8'h1;
         RS_READY:
            rs_next = RS_READY;
         default:
            rs_next = RS_PULSE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rs_reg <= RS_PULSE;
         rcnt_reg <= 8'h0;
      end
      else
      begin
         rs_reg <= rs_next;
         rcnt_reg <= rcnt_next;
      end
   end

   // Sample commands: requests are gathered so pairs fall together
   always_comb
   begin
      ss_next = ss_reg;
      scnt_next = scnt_reg;
      cmd_next = cmd_reg;
      pend_next = pend_reg | sample_req;
      unique case (ss_reg)
         SS_IDLE:
            // Falling edge kept out of the slot just before a clock rise
            if (rs_reg == RS_READY && pend_reg != 3'h0 && !rise_next)
            begin
               cmd_next = pend_reg;
               pend_next = sample_req;
               scnt_next = 4'h0;
               ss_next = SS_LOW;
            end
         SS_LOW:
            if (scnt_reg == 4'(`SAMPLE_LOW_CYC - 1))
            begin
               cmd_next = 3'h0;
               scnt_next = 4'h0;
               ss_next = SS_HIGH;
            end
            else
               scnt_next = scnt_reg + 4'h1;
         SS_HIGH:
            if (scnt_reg == 4'(`SAMPLE_HIGH_CYC - 1))
               ss_next = SS_IDLE;
            else
               scnt_next = scnt_reg + 4'h1;
         default:
            ss_next = SS_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ss_reg <= SS_IDLE;
         scnt_reg <= 4'h0;
         pend_reg <= 3'h0;
         cmd_reg <= 3'h0;
      end
      else
      begin
         ss_reg <= ss_next;
         scnt_reg <= scnt_next;
         pend_reg <= pend_next;
         cmd_reg <= cmd_next;
      end
   end

   // Parallel bus: address setup, strobe, optional second byte, recovery
   always_comb
   begin
      bs_next = bs_reg;
      bcnt_next = bcnt_reg;
      kind_next = kind_reg;
      addr_next = addr_reg;
      wdat_next = wdat_reg;
      rd_data_next = rd_data_reg;
      rd_valid_next = 1'b0;
      byte_next = byte_reg;
      unique case (bs_reg)
         BS_IDLE:
            if (acc_valid && rs_reg == RS_READY)
            begin
               kind_next = acc_kind;
               addr_next = acc_addr;
               wdat_next = acc_wdata;
               byte_next = (acc_kind == ACC_READ8);
               bcnt_next = 4'h0;
               bs_next = BS_SETUP;
            end
         BS_SETUP:
            if (bcnt_reg == 4'(`ADDR_SETUP_CYC - 1))
            begin
               bcnt_next = 4'h0;
               bs_next = BS_STROBE;
            end
            else
               bcnt_next = bcnt_reg + 4'h1;
         BS_STROBE:
            // Data valid time is under the low-width, but both round to two cycles; wait the data valid count
            if (bcnt_reg == 4'(`DATA_VALID_CYC + `READ_LOW_CYC - `READ_LOW_CYC))
            begin
               bcnt_next = 4'h0;
               if (kind_reg == ACC_READ8)
               begin
                  rd_data_next = {result_bus_in[7:0], 8'h00};
                  byte_next = 1'b0;
                  bs_next = BS_HIGH_HALF;
               end
               else
               begin
                  if (kind_reg == ACC_READ16)
                  begin
                     rd_data_next = result_bus_in;
                     rd_valid_next = 1'b1;
                  end
                  bs_next = BS_RECOVER;
               end
            end
            else
               bcnt_next = bcnt_reg + 4'h1;
         BS_HIGH_HALF:
            // Read stays low while the low half settles after byte select drops
            if (bcnt_reg == 4'(`DATA_VALID_CYC))
            begin
               rd_data_next = {rd_data_reg[15:8], result_bus_in[7:0]};
               rd_valid_next = 1'b1;
               bcnt_next = 4'h0;
               bs_next = BS_RECOVER;
            end
            else
               bcnt_next = bcnt_reg + 4'h1;
         BS_RECOVER:
            if (bcnt_reg == 4'(`READ_HIGH_CYC - 1))
               bs_next = BS_IDLE;
            else
               bcnt_next = bcnt_reg + 4'h1;
         default:
            bs_next = BS_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         bs_reg <= BS_IDLE;
         bcnt_reg <= 4'h0;
         kind_reg <= ACC_READ16;
         addr_reg <= 3'h0;
         wdat_reg <= 8'h00;
         rd_data_reg <= 16'h0000;
         rd_valid_reg <= 1'b0;
         byte_reg <= 1'b0;
      end
      else
      begin
         bs_reg <= bs_next;
         bcnt_reg <= bcnt_next;
         kind_reg <= kind_next;
         addr_reg <= addr_next;
         wdat_reg <= wdat_next;
         rd_data_reg <= rd_data_next;
         rd_valid_reg <= rd_valid_next;
         byte_reg <= byte_next;
      end
   end

   // Pin outputs; chip select spans the whole strobe so it wraps read
   assign reset_n = (rs_reg != RS_PULSE);
   assign {pair_c_sample_cmd_n, pair_b_sample_cmd_n, pair_a_sample_cmd_n} = ~cmd_reg;
   assign chip_sel_n = !(bs_reg == BS_SETUP || bs_reg == BS_STROBE
      || bs_reg == BS_HIGH_HALF);
   assign read_n = !((bs_reg == BS_STROBE || bs_reg == BS_HIGH_HALF)
      && kind_reg != ACC_WRITE);
   assign write_n = !(bs_reg == BS_STROBE && kind_reg == ACC_WRITE);
   assign byte_mode = byte_reg;
   assign {addr_line_2, addr_line_1, addr_line_0} = addr_reg;
   // Host drives the low lines only during write setup and strobe; device owns reads
   assign result_bus_out = wdat_reg;
   assign result_bus_oe = {8{(bs_reg == BS_STROBE || bs_reg == BS_SETUP)
      && kind_reg == ACC_WRITE}};
   assign acc_ready = (bs_reg == BS_IDLE) && (rs_reg == RS_READY);
   assign rd_data = rd_data_reg;
   assign rd_valid = rd_valid_reg;
   assign sample_busy = (ss_reg != SS_IDLE) || (pend_reg != 3'h0);
endmodule

// *** hw/adc_host_pkg.sv ***
// Types shared by the converter host controller.
// Assumes the timing header is included by the modules.
package adc_host_pkg;
   typedef enum logic [1:0] {ACC_READ16, ACC_READ8, ACC_WRITE} access_t;
endpackage

// *** hw/adc_host_regs.svh ***
// Timing constants for the six-channel converter host controller.
// Assumes a 25 MHz system clock; all times are worst case (3V interface).
// Overview of operation
// - Read may stay low while byte select toggles between halves.
// - Host supplies conversion clock, period 200 ns, phases 60 ns minimum; the generator here runs a 240 ns period, 120 ns phases.
// - Host holds each sample command low at least 30 ns.
// - Host returns sample command high at least 30 ns before another.
// - Clock rising edge comes at least 10 ns after sample command falls.
// - Host asserts global reset low at least 40 ns.
// - Host waits at least 40 ns after reset before first sample command.
// - Chip select and read stay low together at least 70 ns.
// - Chip select falls no later, and rises no earlier, than read.
// - Address stable at least 20 ns before read falls.
`ifndef ADC_HOST_REGS_SVH
`define ADC_HOST_REGS_SVH
`define SYS_CLK_NS 40
`define CONV_CLK_PERIOD_NS 200
`define CONV_CLK_PHASE_NS 60
`define SAMPLE_LOW_NS 30
`define SAMPLE_HIGH_NS 30
`define CLK_AFTER_SAMPLE_NS 10
`define RESET_LOW_NS 40
`define RESET_TO_SAMPLE_NS 40
`define READ_LOW_NS 70
`define ADDR_SETUP_NS 20
`define READ_HIGH_NS 40
`define DATA_VALID_NS 60
// Cycle counts: least times round up
`define CEIL_CYC(ns) (((ns) + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define CONV_CLK_HALF_CYC 3
`define SAMPLE_LOW_CYC `CEIL_CYC(`SAMPLE_LOW_NS)
`define SAMPLE_HIGH_CYC `CEIL_CYC(`SAMPLE_HIGH_NS)
`define RESET_LOW_CYC `CEIL_CYC(`RESET_LOW_NS)
`define RESET_TO_SAMPLE_CYC `CEIL_CYC(`RESET_TO_SAMPLE_NS)
`define READ_LOW_CYC `CEIL_CYC(`READ_LOW_NS)
`define ADDR_SETUP_CYC `CEIL_CYC(`ADDR_SETUP_NS)
`define READ_HIGH_CYC `CEIL_CYC(`READ_HIGH_NS)
`define DATA_VALID_CYC `CEIL_CYC(`DATA_VALID_NS)
`endif

// *** hw/conv_clk_gen.sv ***
// Conversion clock generator for the converter.
// Assumes a 25 MHz clk; output runs free once out of reset.
`timescale 1ns/100ps
`include "adc_host_regs.svh"
module conv_clk_gen #(
   parameter int HALF_CYC = `CONV_CLK_HALF_CYC
)(
   input wire logic clk,
   input wire logic srst,
   output logic conv_clk,
   output logic rise_next
);
   logic [3:0] cnt_reg, cnt_next;
   logic lvl_reg, lvl_next;

   // Each phase lasts HALF_CYC cycles: 120 ns each, 240 ns period
   always_comb
   begin
      cnt_next = cnt_reg + 4'h1;
      lvl_next = lvl_reg;
      if (cnt_reg == 4'(HALF_CYC - 1))
      begin
         cnt_next = 4'h0;
         lvl_next = ~lvl_reg;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cnt_reg <= 4'h0;
         lvl_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         lvl_reg <= lvl_next;
      end
   end

   assign conv_clk = lvl_reg;
   // Rising edge lands on the next clk edge; sample commands avoid this slot
   assign rise_next = ~lvl_reg && (cnt_reg == 4'(HALF_CYC - 1));
endmodule

// *** hw/eoc_detect.sv ***
// Falling-edge detector for the end-of-conversion strobe.
// Assumes the strobe is synchronous to clk and low for at least one cycle.
`timescale 1ns/100ps
module eoc_detect (
   input wire logic clk,
   input wire logic srst,
   input wire logic conv_done_n,
   output logic done_pulse
);
   logic prev_reg, prev_next;

   // Previous level kept to find the high-to-low step
   always_comb
   begin
      prev_next = conv_done_n;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         prev_reg <= 1'b1;
      else
         prev_reg <= prev_next;
   end

   assign done_pulse = prev_reg & ~conv_done_n;
endmodule

// *** tb/adc_host_properties.sv ***
// Pin-level checks for the converter host controller.
// Assumes it is bound into adc_host and sees only that module's ports.
`timescale 1ns/100ps
module adc_host_properties #(
   parameter int RESET_LOW_CYC = 1
)(
   input wire logic clk,
   input wire logic srst,
   input wire logic conv_clk,
   input wire logic reset_n,
   input wire logic pair_a_sample_cmd_n,
   input wire logic pair_b_sample_cmd_n,
   input wire logic pair_c_sample_cmd_n,
   input wire logic chip_sel_n,
   input wire logic read_n,
   input wire logic addr_line_2,
   input wire logic addr_line_1,
   input wire logic addr_line_0,
   input wire logic [7:0] result_bus_oe,
   input wire logic conv_done_n,
   input wire logic conv_done,
   input wire logic rd_valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // The three sample command levels, pair c down to pair a
   wire logic [2:0] cmd_n = {pair_c_sample_cmd_n, pair_b_sample_cmd_n, pair_a_sample_cmd_n};
   // Converter reset low stretch after srst releases; saturates so it never wraps
   logic [7:0] rst_low_cnt_reg;
   always_ff @(posedge clk)
   begin
      if (srst || reset_n)
         rst_low_cnt_reg <= 8'h00;
      else if (rst_low_cnt_reg != 8'hff)
         rst_low_cnt_reg <= rst_low_cnt_reg + 8'h01;
   end

   rd_in_sel_a: assert property (!read_n |-> !chip_sel_n)
      else $error("read low without chip select");
   addr_setup_a: assert property ($fell(read_n)
      |-> $stable({addr_line_2, addr_line_1, addr_line_0}))
      else $error("address moved as read fell");
   rd_low_len_a: assert property ($fell(read_n) |-> !read_n ##1 !read_n)
      else $error("read strobe too short");
   rst_low_a: assert property ($rose(reset_n) |-> rst_low_cnt_reg >= 8'(RESET_LOW_CYC))
      else $error("converter reset too short");
   hold_after_rst_a: assert property (|(~cmd_n & $past(cmd_n))
      |-> reset_n && $past(reset_n))
      else $error("sample command too soon after reset");
   hold_vs_clk_a: assert property (|(~cmd_n & $past(cmd_n)) |-> !$rose(conv_clk))
      else $error("conversion clock rose with sample command");
   clk_period_a: assert property ($rose(conv_clk) |=> !$rose(conv_clk) [*4])
      else $error("conversion clock period too short");
   clk_phase_a: assert property ($changed(conv_clk) |=> $stable(conv_clk))
      else $error("conversion clock phase too short");
   no_fight_a: assert property (|result_bus_oe |-> read_n)
      else $error("host drives data lines during read");
   done_flag_a: assert property (conv_done == $fell(conv_done_n))
      else $error("done pulse does not match end strobe");
   rd_result_a: assert property ($rose(read_n) |-> rd_valid)
      else $error("no result after read strobe");

   cover property ($fell(read_n));
   cover property (|result_bus_oe);
   cover property ($fell(conv_done_n));
endmodule

bind adc_host adc_host_properties #(.RESET_LOW_CYC(RESET_LOW_CYC)) u_adc_host_properties (
   .clk(clk), .srst(srst), .conv_clk(conv_clk), .reset_n(reset_n),
   .pair_a_sample_cmd_n(pair_a_sample_cmd_n), .pair_b_sample_cmd_n(pair_b_sample_cmd_n),
   .pair_c_sample_cmd_n(pair_c_sample_cmd_n), .chip_sel_n(chip_sel_n), .read_n(read_n),
   .addr_line_2(addr_line_2), .addr_line_1(addr_line_1), .addr_line_0(addr_line_0),
   .result_bus_oe(result_bus_oe), .conv_done_n(conv_done_n), .conv_done(conv_done),
   .rd_valid(rd_valid));

// *** tb/adc_host_test.sv ***
// Self-checking bench for the converter host controller.
// Assumes the device model answers on the far side of the pins.
`timescale 1ns/100ps
module adc_host_test;
   import adc_host_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [2:0] sample_req = 3'h0;
   logic acc_valid = 1'b0;
   access_t acc_kind = ACC_READ16;
   logic [2:0] acc_addr = 3'h0;
   logic [7:0] acc_wdata = 8'h00;
   logic sample_busy, acc_ready, rd_valid, conv_done, conv_clk, reset_n, write_n, byte_mode;
   logic cmd_a_n, cmd_b_n, cmd_c_n, chip_sel_n, read_n, al2, al1, al0, conv_done_n;
   logic [15:0] rd_data, result_bus;
   logic [7:0] bus_out, bus_oe, sw_bits;
   logic [2:0] held_pairs;
   int n_fail = 0;
   int num_checks = 0;

   // 25 MHz clock
   always #20 clk = ~clk;

   adc_host u_adc_host (.clk(clk), .srst(srst), .sample_req(sample_req),
      .sample_busy(sample_busy), .acc_valid(acc_valid), .acc_kind(acc_kind),
      .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_ready(acc_ready), .rd_data(rd_data),
      .rd_valid(rd_valid), .conv_done(conv_done), .conv_clk(conv_clk), .reset_n(reset_n),
      .pair_a_sample_cmd_n(cmd_a_n), .pair_b_sample_cmd_n(cmd_b_n),
      .pair_c_sample_cmd_n(cmd_c_n), .chip_sel_n(chip_sel_n), .read_n(read_n),
      .write_n(write_n), .byte_mode(byte_mode), .addr_line_2(al2), .addr_line_1(al1),
      .addr_line_0(al0), .result_bus_in(result_bus), .result_bus_out(bus_out),
      .result_bus_oe(bus_oe), .conv_done_n(conv_done_n), .first_word_flag(1'b0));

   conv_device_model u_conv_device_model (.clk(clk), .conv_clk(conv_clk), .reset_n(reset_n),
      .pair_a_sample_cmd_n(cmd_a_n), .pair_b_sample_cmd_n(cmd_b_n),
      .pair_c_sample_cmd_n(cmd_c_n), .chip_sel_n(chip_sel_n), .read_n(read_n),
      .write_n(write_n), .byte_mode(byte_mode), .addr_line_2(al2), .addr_line_1(al1),
      .addr_line_0(al0), .host_out(bus_out), .host_oe(bus_oe), .result_bus(result_bus),
      .conv_done_n(conv_done_n), .sw_bits(sw_bits), .held_pairs(held_pairs));

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Hangs count as a mismatch and end the run
   task automatic timed_out(input string what);
      n_fail++;
      $display("BAD %s expected answer seen timeout", what);
      wrap_up();
   endtask

   // One user request, held until taken, then its answer awaited
   task automatic access(input access_t k, input logic [2:0] a, input logic [7:0] d,
                         output logic [15:0] q);
      int i;
      @(posedge clk);
      acc_kind <= k;
      acc_addr <= a;
      acc_wdata <= d;
      acc_valid <= 1'b1;
      // Ready is looked at mid-cycle, never in the edge that updates it
      for (i = 0; i < 50; i++)
      begin
         @(negedge clk);
         if (acc_ready === 1'b1)
            break;
      end
      if (i == 50)
         timed_out("ready");
      @(posedge clk);
      acc_valid <= 1'b0;
      for (i = 0; i < 50; i++)
      begin
         @(negedge clk);
         if (k == ACC_WRITE ? write_n === 1'b0 : rd_valid === 1'b1)
            break;
      end
      if (i == 50)
         timed_out("answer");
      q = rd_data;
   endtask

   task automatic t_read16();
      logic [15:0] q;
      for (int a = 0; a < 8; a++)
      begin
         access(ACC_READ16, 3'(a), 8'h00, q);
         chk("read16", {5'h15, 3'(a), 8'h3c}, q);
      end
      $display("test read16 done");
   endtask

   task automatic t_read8();
      logic [15:0] q;
      access(ACC_READ8, 3'h6, 8'h00, q);
      chk("read8", {5'h15, 3'h6, 8'h3c}, q);
      $display("test read8 done");
   endtask

   // Write, four cycles' wait, then a read: the host must release the lines
   task automatic t_write();
      logic [15:0] q;
      access(ACC_WRITE, 3'h0, 8'h96, q);
      repeat (4) @(posedge clk);
      chk("sw_bits", 16'h0096, {8'h00, sw_bits});
      access(ACC_READ16, 3'h1, 8'h00, q);
      chk("read_after_write", {5'h15, 3'h1, 8'h3c}, q);
      $display("test write done");
   endtask

   task automatic t_sample(input logic [2:0] req, input logic [2:0] exp_pairs);
      int i;
      logic seen_busy;
      seen_busy = 1'b0;
      @(posedge clk);
      sample_req <= req;
      @(posedge clk);
      sample_req <= 3'h0;
      for (i = 0; i < 300 && conv_done !== 1'b1; i++)
      begin
         @(negedge clk);
         seen_busy = seen_busy | (sample_busy === 1'b1);
      end
      if (i == 300)
         timed_out("conv_done");
      chk("busy", 16'h0001, {15'h0, seen_busy});
      chk("pairs", {13'h0, exp_pairs}, {13'h0, held_pairs});
      $display("test sample done");
   endtask

   // Mid-run reset: converter reset follows, then one settle cycle before access
   task automatic t_reset();
      @(posedge clk);
      srst <= 1'b1;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      chk("reset_n_low", 16'h0000, {15'h0, reset_n});
      chk("pairs_cleared", 16'h0000, {13'h0, held_pairs});
      @(negedge clk);
      chk("reset_n_high", 16'h0001, {15'h0, reset_n});
      chk("ready_early", 16'h0000, {15'h0, acc_ready});
      @(negedge clk);
      chk("ready_after", 16'h0001, {15'h0, acc_ready});
      $display("test reset done");
   endtask

   // Main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      t_read16();
      t_read8();
      t_write();
      t_sample(3'h1, 3'h1);
      t_sample(3'h6, 3'h7);
      t_reset();
      t_sample(3'h2, 3'h2);
      wrap_up();
   end
endmodule

// *** tb/conv_device_model.sv ***
// Behavioural model of the six-channel converter's digital pins.
// Assumes all host pins change on clk edges; conv_clk is sampled on clk.
`timescale 1ns/100ps
module conv_device_model #(
   parameter int CONV_EDGES = 4
)(
   input wire logic clk,
   input wire logic conv_clk,
   input wire logic reset_n,
   input wire logic pair_a_sample_cmd_n,
   input wire logic pair_b_sample_cmd_n,
   input wire logic pair_c_sample_cmd_n,
   input wire logic chip_sel_n,
   input wire logic read_n,
   input wire logic write_n,
   input wire logic byte_mode,
   input wire logic addr_line_2,
   input wire logic addr_line_1,
   input wire logic addr_line_0,
   input wire logic [7:0] host_out,
   input wire logic [7:0] host_oe,
   output logic [15:0] result_bus,
   output logic conv_done_n,
   output logic [7:0] sw_bits,
   output logic [2:0] held_pairs
);
   logic [15:0] last_reg = 16'h0;
   logic [15:0] word;
   logic [15:0] dev_val;
   logic [2:0] cmd_reg;
   logic [2:0] cnt_reg;
   logic [1:0] rd_low_reg;
   logic busy_reg;
   logic cc_reg;
   wire logic [2:0] cmd_n = {pair_c_sample_cmd_n, pair_b_sample_cmd_n, pair_a_sample_cmd_n};
   // Word carries its address, so a wrong channel shows at once
   assign word = {5'h15, addr_line_2, addr_line_1, addr_line_0, 8'h3c};
   // Released lines show a changing pattern; data is junk until valid
   always_comb
   begin
      if (chip_sel_n || read_n || rd_low_reg != 2'h3)
         dev_val = ~last_reg;
      else if (byte_mode)
         dev_val = {~last_reg[15:8], word[15:8]};
      else
         dev_val = word;
      result_bus = (dev_val & ~{8'h00, host_oe}) | {8'h00, host_out & host_oe};
   end
   // Bus history, write capture and the conversion sequencer
   always_ff @(posedge clk)
   begin
      last_reg <= result_bus;
      cc_reg <= conv_clk;
      cmd_reg <= cmd_n;
      rd_low_reg <= {rd_low_reg[0], !chip_sel_n && !read_n};
      if (!chip_sel_n && !write_n)
         sw_bits <= result_bus[7:0];
      if (!reset_n)
      begin
         busy_reg <= 1'b0;
         conv_done_n <= 1'b1;
         held_pairs <= 3'h0;
      end
      else if (|(cmd_reg & ~cmd_n))
      begin
         busy_reg <= 1'b1;
         cnt_reg <= 3'h0;
         held_pairs <= held_pairs | (cmd_reg & ~cmd_n);
      end
      else if (busy_reg && conv_clk && !cc_reg)
      begin
         cnt_reg <= cnt_reg + 3'h1;
         if (int'(cnt_reg) == CONV_EDGES - 1)
         begin
            busy_reg <= 1'b0;
            conv_done_n <= 1'b0;
         end
      end
      else if (!conv_clk && cc_reg)
         conv_done_n <= 1'b1;
   end
endmodule
